// file: design/bscan_defs.svh
// Shared constants for the boundary scan and indirect access block
`ifndef BSCAN_DEFS_SVH
`define BSCAN_DEFS_SVH
`define IR_W        16
`define IR_EXTEST   16'h0000
`define IR_SAMPLE   16'h0002
`define IR_IDENT    16'h0004
`define IR_BYPASS   16'hFFFF
`define IR_IND_LO   16'h0082
`define IR_IND_HI   16'h0085
`define IR_CAPTURE  16'h0001
`define BSR_FULL    126
`define BSR_RED     118
`define PAIRS       63
`define RST_PAIR_F  0
`define RST_PAIR_R  36
`define CLK_PAIR    3
`define WPU_CELL    7
`define IND_W       20
`define PAY_W       18
`define ID_W        32
`endif

// file: design/bscan_pkg.sv
// Types shared by the boundary scan and indirect access block
`include "bscan_defs.svh"
package bscan_pkg;
	typedef enum logic [3:0] {
		TAP_TLR, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
		TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
		TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
	} tap_state_type;

	typedef struct packed {
		logic oe;
		logic out;
	} pin_drive_type;

	typedef struct packed {
		logic               write;
		logic [1:0]         target;
		logic [`PAY_W-1:0]  payload;
	} ind_cmd_type;
endpackage : bscan_pkg

// file: design/bscan_indirect_access.sv
// Test port data registers, boundary cells and indirect register access engine
`timescale 1ns/1ps
`include "bscan_defs.svh"
module bscan_indirect_access #(
	parameter bit          FULL_PIN        = 1'b1,
	// Arbitrary neutral identity value; bit 0 is 1 as the scan standard needs
	parameter logic [31:0] DEVICE_IDENTITY = 32'h0ABC_0001
) (
	input  wire logic                                core_clk_i,
	input  wire logic                                rst_n_i,
	input  wire logic                                scan_tck_i,
	input  wire logic                                tms_i,
	input  wire logic                                tdi_i,
	output logic                                     tdo_o,
	output logic                                     tdo_oe_o,
	input  wire bscan_pkg::pin_drive_type [`PAIRS-1:0] pin_core_i,
	input  wire logic [`PAIRS-1:0]                   pin_pad_i,
	output bscan_pkg::pin_drive_type [`PAIRS-1:0]      pin_pad_o,
	output logic [`PAIRS-1:0]                        pin_core_in_o,
	input  wire logic                                crystal_input_pin_i,
	input  wire logic                                wpu_core_i,
	output logic                                     wpu_pin_o,
	output logic                                     acc_req_o,
	output logic                                     acc_write_o,
	output logic [1:0]                               acc_target_o,
	output logic [`PAY_W-1:0]                        acc_payload_o,
	input  wire logic                                acc_ack_i,
	input  wire logic [`PAY_W-1:0]                   acc_rdata_i
);
	import bscan_pkg::*;

	localparam int BSR_LEN  = FULL_PIN ? `BSR_FULL : `BSR_RED;
	localparam int RST_PAIR = FULL_PIN ? `RST_PAIR_F : `RST_PAIR_R;
	localparam int CELLS    = 2 * `PAIRS;

	typedef struct packed {
		tap_state_type       st;
		logic [`IR_W-1:0]    ir_sr;
		logic [`IR_W-1:0]    ir;
		logic                ext;
		logic [CELLS-1:0]    cap1;
		logic [CELLS-1:0]    cap2;
		logic [CELLS-1:0]    bsr;
		logic [CELLS-1:0]    upd;
		logic                upd_tgl;
		logic [`ID_W-1:0]    id_sr;
		logic                byp;
		logic [`IND_W-1:0]   ind_sr;
		logic                cap_busy;
		logic                busy;
		ind_cmd_type         cmd;
		logic                cmd_tgl;
		logic                done_s1;
		logic                done_s2;
		logic                done_seen;
	} tck_state_type;

	typedef struct packed {
		logic                cmd_s1;
		logic                cmd_s2;
		logic                cmd_seen;
		logic                req;
		ind_cmd_type         cmd;
		logic [`PAY_W-1:0]   rd;
		logic                done_tgl;
		logic                ext_s1;
		logic                ext_s2;
		logic                upd_s1;
		logic                upd_s2;
		logic                upd_seen;
		logic [CELLS-1:0]    upd;
		logic [`PAIRS-1:0]   pad_s1;
		logic [`PAIRS-1:0]   pad_s2;
		pin_drive_type [`PAIRS-1:0] pad;
		logic [`PAIRS-1:0]   core_in;
		logic                wpu;
	} core_state_type;

	tck_state_type  t_q;
	tck_state_type  t_d;
	core_state_type c_q;
	core_state_type c_d;
	logic [CELLS-1:0] cap_raw;
	logic           tdo_q;
	logic           tdo_oe_q;

	////////////////////////////////////////////////////////////////////////////
	function automatic tap_state_type tap_next(input tap_state_type s, input logic m);
		unique case (s)
			TAP_TLR:    tap_next = m ? TAP_TLR : TAP_IDLE;
			TAP_IDLE:   tap_next = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR:  tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAU_DR;
			TAP_PAU_DR: tap_next = m ? TAP_EX2_DR : TAP_PAU_DR;
			TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_next = m ? TAP_TLR : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR:  tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAU_IR;
			TAP_PAU_IR: tap_next = m ? TAP_EX2_IR : TAP_PAU_IR;
			TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
			TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
		endcase
	endfunction : tap_next

	function automatic logic is_ind(input logic [`IR_W-1:0] ir);
		is_ind = (ir >= `IR_IND_LO) && (ir <= `IR_IND_HI);
	endfunction : is_ind

	function automatic logic is_bsr(input logic [`IR_W-1:0] ir);
		is_bsr = (ir == `IR_EXTEST) || (ir == `IR_SAMPLE);
	endfunction : is_bsr

	// true except for cells whose update stage drives no pad or is absent
	function automatic logic upd_ok(input int p, input logic odd);
		upd_ok = (p != `CLK_PAIR) && !(!FULL_PIN && p == 0) && (2 * p + 1 < BSR_LEN)
			&& !(odd && p == RST_PAIR);
	endfunction : upd_ok

	function automatic logic dr_tail(input tck_state_type s);
		if (is_bsr(s.ir))
			dr_tail = s.bsr[0];
		else if (s.ir == `IR_IDENT)
			dr_tail = s.id_sr[0];
		else if (is_ind(s.ir))
			dr_tail = s.ind_sr[0];
		else
			dr_tail = s.byp;
	endfunction : dr_tail

	////////////////////////////////////////////////////////////////////////////
	// even cell takes core enable, odd cell the pad level
	genvar g;
	generate
		for (g = 0; g < `PAIRS; g++) begin : g_cap
			if (g == `CLK_PAIR) begin : g_clk
				// crystal level and core weak-pullup enable
				assign cap_raw[2*g]   = crystal_input_pin_i;
				assign cap_raw[2*g+1] = wpu_core_i;
			end else if (g == 0 && !FULL_PIN) begin : g_unused
				// cells 0 and 1 capture nothing
				assign cap_raw[1:0] = 2'h0;
			end else begin : g_pin
				assign cap_raw[2*g]   = pin_core_i[g].oe;
				assign cap_raw[2*g+1] = pin_pad_i[g];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Scan clock domain
	always_comb begin
		t_d = t_q;
		t_d.st = tap_next(t_q.st, tms_i);
		// Pins and core levels are asynchronous to the scan clock
		t_d.cap1 = cap_raw;
		t_d.cap2 = t_q.cap1;
		t_d.done_s1 = c_q.done_tgl;
		t_d.done_s2 = t_q.done_s1;
		if (t_q.done_s2 != t_q.done_seen) begin
			t_d.done_seen = t_q.done_s2;
			t_d.busy = 1'b0;
		end
		unique case (t_q.st)
			TAP_TLR: begin
				t_d.ir = `IR_IDENT;
			end
			TAP_CAP_IR: begin
				t_d.ir_sr = `IR_CAPTURE;
			end
			TAP_SH_IR: begin
				t_d.ir_sr = {tdi_i, t_q.ir_sr[`IR_W-1:1]};
			end
			TAP_UPD_IR: begin
				t_d.ir = t_q.ir_sr;
			end
			TAP_CAP_DR: begin
				t_d.bsr = t_q.cap2;
				t_d.id_sr = DEVICE_IDENTITY;
				t_d.byp = 1'b0;
				// busy at bit 0, read data right-justified above it
				t_d.ind_sr = {1'b0, c_q.rd, t_q.busy};
				t_d.cap_busy = t_q.busy;
			end
			TAP_SH_DR: begin
				if (is_bsr(t_q.ir)) begin
					t_d.bsr = t_q.bsr >> 1;
					t_d.bsr[BSR_LEN-1] = tdi_i;
				end else if (t_q.ir == `IR_IDENT)
					t_d.id_sr = {tdi_i, t_q.id_sr[`ID_W-1:1]};
				else if (is_ind(t_q.ir))
					t_d.ind_sr = {tdi_i, t_q.ind_sr[`IND_W-1:1]};
				else
					t_d.byp = tdi_i;
			end
			TAP_UPD_DR: begin
				if (is_bsr(t_q.ir)) begin
					// sample also presets the update latches
					t_d.upd = t_q.bsr;
					t_d.upd_tgl = ~t_q.upd_tgl;
				end
				// poll never launches; busy at capture blocks
				if (is_ind(t_q.ir) && t_q.ind_sr[`IND_W-1] && !t_q.cap_busy
					&& !t_q.busy) begin
					// read from two bits; payload left-justified
					t_d.cmd.write = t_q.ind_sr[`IND_W-2];
					t_d.cmd.target = 2'(t_q.ir[1:0] - 2'h2);
					t_d.cmd.payload = t_q.ind_sr[`PAY_W-1:0];
					t_d.busy = 1'b1;
					t_d.cmd_tgl = ~t_q.cmd_tgl;
				end
			end
			default: begin
			end
		endcase
		// Follows the new instruction at once: the scan clock may stop after Update-IR
		t_d.ext = (t_d.ir == `IR_EXTEST);
	end

	always_ff @(posedge scan_tck_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			t_q <= '0;
			t_q.st <= TAP_TLR;
			t_q.ir <= `IR_IDENT;
		end else begin
			t_q <= t_d;
		end
	end

	// Data out changes on the falling scan edge, as the scan standard times it
	always_ff @(negedge scan_tck_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tdo_q <= 1'b0;
			tdo_oe_q <= 1'b0;
		end else begin
			tdo_oe_q <= (t_q.st == TAP_SH_IR) || (t_q.st == TAP_SH_DR);
			tdo_q <= (t_q.st == TAP_SH_IR) ? t_q.ir_sr[0] : dr_tail(t_q);
		end
	end

	assign tdo_o = tdo_q;
	assign tdo_oe_o = tdo_oe_q;

	////////////////////////////////////////////////////////////////////////////
	// Core clock domain
	always_comb begin
		c_d = c_q;
		c_d.cmd_s1 = t_q.cmd_tgl;
		c_d.cmd_s2 = c_q.cmd_s1;
		c_d.ext_s1 = t_q.ext;
		c_d.ext_s2 = c_q.ext_s1;
		c_d.upd_s1 = t_q.upd_tgl;
		c_d.upd_s2 = c_q.upd_s1;
		c_d.pad_s1 = pin_pad_i;
		c_d.pad_s2 = c_q.pad_s1;
		// Scan side holds the command stable while busy, so a toggle suffices
		if (c_q.cmd_s2 != c_q.cmd_seen && !c_q.req) begin
			c_d.cmd_seen = c_q.cmd_s2;
			c_d.cmd = t_q.cmd;
			c_d.req = 1'b1;
		end
		if (c_q.req && acc_ack_i) begin
			c_d.req = 1'b0;
			if (!c_q.cmd.write)
				c_d.rd = acc_rdata_i;
			c_d.done_tgl = ~c_q.done_tgl;
		end
		if (c_q.upd_s2 != c_q.upd_seen) begin
			c_d.upd_seen = c_q.upd_s2;
			c_d.upd = t_q.upd;
		end
		// core sees all ones under external test
		c_d.core_in = c_q.ext_s2 ? '1 : c_q.pad_s2;
		// update values reach pins only under external test
		for (int p = 0; p < `PAIRS; p++) begin
			c_d.pad[p].oe = (c_q.ext_s2 && upd_ok(p, 1'b0)) ? c_q.upd[2*p]
				: pin_core_i[p].oe;
			c_d.pad[p].out = (c_q.ext_s2 && upd_ok(p, 1'b1)) ? c_q.upd[2*p+1]
				: pin_core_i[p].out;
		end
		c_d.wpu = c_q.ext_s2 ? c_q.upd[`WPU_CELL] : wpu_core_i;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			c_q <= '0;
		else
			c_q <= c_d;
	end

	assign pin_pad_o = c_q.pad;
	assign pin_core_in_o = c_q.core_in;
	assign wpu_pin_o = c_q.wpu;
	assign acc_req_o = c_q.req;
	assign acc_write_o = c_q.cmd.write;
	assign acc_target_o = c_q.cmd.target;
	assign acc_payload_o = c_q.cmd.payload;

	////////////////////////////////////////////////////////////////////////////
	a_extest_force_in: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		c_q.ext_s2 |=> pin_core_in_o == '1) else $error("core input not forced high");
	a_sample_no_drive: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!c_q.ext_s2 |=> pin_pad_o[9] == $past(pin_core_i[9]))
		else $error("pin driven outside external test");
	a_poll_no_launch: assert property (@(posedge scan_tck_i) disable iff (!rst_n_i)
		(t_q.st == TAP_UPD_DR && !t_q.ind_sr[`IND_W-1]) |=> $stable(t_q.cmd_tgl))
		else $error("poll launched an access");
	a_read_launch: assert property (@(posedge scan_tck_i) disable iff (!rst_n_i)
		(t_q.st == TAP_UPD_DR && is_ind(t_q.ir) && !t_q.busy && !t_q.cap_busy
		&& t_q.ind_sr[`IND_W-1:`IND_W-2] == 2'b10) |=> t_q.busy && !t_q.cmd.write)
		else $error("read not launched");
	a_busy_ignore: assert property (@(posedge scan_tck_i) disable iff (!rst_n_i)
		(t_q.st == TAP_UPD_DR && t_q.busy) |=> $stable(t_q.cmd) && $stable(t_q.cmd_tgl))
		else $error("command taken while busy");
	a_write_payload: assert property (@(posedge scan_tck_i) disable iff (!rst_n_i)
		(t_q.st == TAP_UPD_DR && is_ind(t_q.ir) && !t_q.busy && !t_q.cap_busy
		&& t_q.ind_sr[`IND_W-1:`IND_W-2] == 2'b11)
		|=> t_q.cmd.write && t_q.cmd.payload == $past(t_q.ind_sr[`PAY_W-1:0]))
		else $error("write payload wrong");
	a_ident_capture: assert property (@(posedge scan_tck_i) disable iff (!rst_n_i)
		(t_q.st == TAP_CAP_DR && t_q.ir == `IR_IDENT) ##1 t_q.st == TAP_SH_DR
		|-> t_q.id_sr == DEVICE_IDENTITY) else $error("identity not captured");
	a_ind_busy_out: assert property (@(posedge scan_tck_i) disable iff (!rst_n_i)
		t_q.st == TAP_CAP_DR |=> t_q.ind_sr[0] == $past(t_q.busy))
		else $error("busy not at bit 0");
	a_bypass_zero: assert property (@(posedge scan_tck_i) disable iff (!rst_n_i)
		t_q.st == TAP_CAP_DR |=> !t_q.byp) else $error("bypass not cleared");
	a_access_done: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(acc_req_o && acc_ack_i) |=> !acc_req_o ##0 c_q.done_tgl != $past(c_q.done_tgl))
		else $error("access completion lost");

	c_read: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		acc_req_o && !acc_write_o && acc_ack_i);
	c_write: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		acc_req_o && acc_write_o && acc_ack_i);
	c_extest: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		c_q.ext_s2 && c_q.upd_s2 != c_q.upd_seen);
	c_busy_poll: cover property (@(posedge scan_tck_i) disable iff (!rst_n_i)
		t_q.st == TAP_CAP_DR && t_q.busy);
endmodule : bscan_indirect_access

// file: verification/scan_tester.sv
// Test port tester model: drives the scan link and runs indirect accesses
`timescale 1ns/1ps
module scan_tester (
	output logic      scan_tck_o,
	output logic      tms_o,
	output logic      tdi_o,
	input  wire logic tdo_i
);
	// Scan clock stands low between frames
	initial begin
		scan_tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b0;
	end

	task automatic tick(input logic m, input logic d, output logic q);
		tms_o = m;
		tdi_o = d;
		#16;
		q = tdo_i;
		scan_tck_o = 1'b1;
		#16;
		scan_tck_o = 1'b0;
	endtask : tick

	task automatic tap_reset();
		logic q;
		repeat (5) tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
	endtask : tap_reset

	// One scan from idle back to idle, bit 0 shifted first
	task automatic scan(input bit ir, input int n, input logic [159:0] din,
		output logic [159:0] dout);
		logic q;
		dout = '0;
		tick(1'b1, 1'b0, q);
		if (ir) begin
			tick(1'b1, 1'b0, q);
		end
		tick(1'b0, 1'b0, q);
		tick(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], q);
			dout[i] = q;
		end
		tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
	endtask : scan

	task automatic select(input logic [15:0] code);
		logic [159:0] o;
		scan(1'b1, 16, {144'h0, code}, o);
	endtask : select

	// only the top n command bits shifted
	task automatic command(input logic [19:0] cmd, input int n);
		logic [159:0] d;
		logic [159:0] o;
		d = '0;
		for (int i = 0; i < n; i++) begin
			d[i] = cmd[20 - n + i];
		end
		scan(1'b0, n, d, o);
	endtask : command

	task automatic wait_idle(output logic busy);
		logic [159:0] o;
		busy = 1'b1;
		for (int k = 0; k < 300 && busy !== 1'b0; k++) begin
			scan(1'b0, 1, 160'h0, o);
			busy = o[0];
		end
	endtask : wait_idle
endmodule : scan_tester

// file: verification/tb_top.sv
// Self-checking bench for the boundary scan and indirect access block
`timescale 1ns/1ps
`include "bscan_defs.svh"
module tb_top;
	import bscan_pkg::*;
	// Arbitrary identity value, bit 0 set
	localparam logic [31:0] IDENT = 32'h1357_2469;
	localparam logic [17:0] RDATA = 18'h2_A3C9;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic scan_tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o;
	pin_drive_type [`PAIRS-1:0] pin_core_i, pin_pad_o;
	logic [`PAIRS-1:0] pin_pad_i, pin_core_in_o;
	logic crystal_input_pin_i = 1'b1;
	logic wpu_core_i = 1'b0;
	logic wpu_pin_o, acc_req_o, acc_write_o;
	logic [1:0] acc_target_o;
	logic [17:0] acc_payload_o;
	logic acc_ack_i = 1'b0;
	logic [17:0] acc_rdata_i = RDATA;
	ind_cmd_type seen;
	int failures = 0;
	int checks_done = 0;
	int req_cnt = 0;
	int ack_dly = 2;

	always #2.5 core_clk_i = ~core_clk_i;

	bscan_indirect_access #(.FULL_PIN(1'b1), .DEVICE_IDENTITY(IDENT)) u_dut (
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .scan_tck_i(scan_tck_i),
		.tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
		.pin_core_i(pin_core_i), .pin_pad_i(pin_pad_i), .pin_pad_o(pin_pad_o),
		.pin_core_in_o(pin_core_in_o), .crystal_input_pin_i(crystal_input_pin_i),
		.wpu_core_i(wpu_core_i), .wpu_pin_o(wpu_pin_o), .acc_req_o(acc_req_o),
		.acc_write_o(acc_write_o), .acc_target_o(acc_target_o),
		.acc_payload_o(acc_payload_o), .acc_ack_i(acc_ack_i), .acc_rdata_i(acc_rdata_i));
	scan_tester u_tst (.scan_tck_o(scan_tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_o));

	// Core side answers each access after ack_dly cycles
	always begin
		@(negedge core_clk_i);
		if (acc_req_o === 1'b1) begin
			req_cnt++;
			seen = '{acc_write_o, acc_target_o, acc_payload_o};
			repeat (ack_dly) @(negedge core_clk_i);
			acc_ack_i = 1'b1;
			@(negedge core_clk_i);
			acc_ack_i = 1'b0;
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chk_vec(input string what, input logic [125:0] exp, input logic [125:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_vec

	function automatic logic [125:0] captured();
		logic [125:0] e;
		for (int p = 0; p < 63; p++) begin
			e[2*p] = pin_core_i[p].oe;
			e[2*p+1] = pin_pad_i[p];
		end
		e[6] = crystal_input_pin_i;
		e[7] = wpu_core_i;
		return e;
	endfunction : captured

	// Pads in cell order; pair 3 has no pad, so it is masked
	task automatic chk_pads(input logic [125:0] u, input bit ext);
		logic [125:0] e;
		logic [125:0] g;
		for (int p = 0; p < 63; p++) begin
			e[2*p] = ext ? u[2*p] : pin_core_i[p].oe;
			e[2*p+1] = ext ? u[2*p+1] : pin_core_i[p].out;
			g[2*p] = pin_pad_o[p].oe;
			g[2*p+1] = pin_pad_o[p].out;
		end
		e[1] = pin_core_i[0].out;
		e[7:6] = 2'b00;
		g[7:6] = 2'b00;
		chk_vec("pad drive", e, g);
		chk("weak pullup", {31'h0, ext ? u[7] : wpu_core_i}, {31'h0, wpu_pin_o});
		chk_vec("core inputs", {63'h0, ext ? {63{1'b1}} : pin_pad_i},
			{63'h0, pin_core_in_o});
	endtask : chk_pads

	task automatic t_ident();
		logic [159:0] o;
		u_tst.scan(1'b0, 32, 160'h0, o);
		chk("reset identity", IDENT, o[31:0]);
		u_tst.scan(1'b1, 16, 160'h4, o);
		chk("ir capture", 32'h1, {16'h0, o[15:0]});
		u_tst.scan(1'b0, 32, 160'h0, o);
		chk("identity", IDENT, o[31:0]);
		chk("tdo enable idle", 32'h0, {31'h0, tdo_oe_o});
	endtask : t_ident

	// Unknown codes fall back to bypass as well
	task automatic t_bypass(input logic [15:0] code);
		logic [159:0] o;
		u_tst.select(code);
		u_tst.scan(1'b0, 8, 160'hB3, o);
		chk("bypass", 32'h66, {24'h0, o[7:0]});
	endtask : t_bypass

	task automatic t_boundary();
		logic [159:0] o;
		logic [125:0] u;
		u = {63'h35A9_C3D2_0F1E_6B47, 63'h1C6E_92B5_A0D7_4F38};
		u_tst.select(16'h0002);
		// Eight extra bits show the register length
		u_tst.scan(1'b0, 134, {26'h0, u, 8'hC5}, o);
		chk_vec("sample capture", captured(), o[125:0]);
		chk("length", 32'hC5, {24'h0, o[133:126]});
		#100;
		chk_pads(u, 1'b0);
		u_tst.select(16'h0000);
		#100;
		chk_pads(u, 1'b1);
		u_tst.scan(1'b0, 126, {34'h0, ~u}, o);
		#100;
		chk_pads(~u, 1'b1);
		u_tst.select(16'h0004);
		#100;
		chk_pads(~u, 1'b0);
	endtask : t_boundary

	task automatic t_indirect();
		logic [159:0] o;
		logic b;
		ack_dly = 2;
		for (int t = 0; t < 4; t++) begin
			req_cnt = 0;
			u_tst.select(16'(16'h0082 + t));
			u_tst.command({2'b11, 8'(8'h5A ^ t), 10'h0}, 10);
			u_tst.wait_idle(b);
			chk("write idle", 32'h0, {31'h0, b});
			chk("write count", 32'h1, req_cnt);
			chk("write cmd", {21'h0, 1'b1, 2'(t), 8'(8'h5A ^ t)},
				{21'h0, seen.write, seen.target, seen.payload[17:10]});
		end
		ack_dly = 300;
		req_cnt = 0;
		u_tst.command({2'b10, 18'h0}, 2);
		// Sent while the read is still busy
		u_tst.command({2'b11, 18'h3_FFFF}, 20);
		u_tst.wait_idle(b);
		chk("read idle", 32'h0, {31'h0, b});
		chk("read count", 32'h1, req_cnt);
		chk("read cmd", 32'h3, {29'h0, seen.write, seen.target});
		u_tst.scan(1'b0, 19, 160'h0, o);
		chk("read data", {13'h0, RDATA, 1'b0}, {13'h0, o[18:0]});
		// Give a wrongly launched access time to reach the core side
		#100;
		chk("no relaunch", 32'h1, req_cnt);
	endtask : t_indirect

	task automatic stop_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test

	initial begin
		logic q;
		for (int p = 0; p < 63; p++) begin
			pin_core_i[p] = '{p[0], p[1]};
		end
		pin_pad_i = 63'h2D4B_1E87_9C3F_60A5;
		u_tst.tick(1'b1, 1'b0, q);
		repeat (16) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		u_tst.tap_reset();
		t_ident();
		t_bypass(16'hFFFF);
		t_bypass(16'h1234);
		t_boundary();
		t_indirect();
		stop_test();
	end

	initial begin
		#400_000;
		failures++;
		stop_test();
	end
endmodule : tb_top
